//--- fls_pkg.sv
// shared constants and types of the flash status poller
package fls_pkg;
  // widths of the flash bus
  localparam int AW = 20;
  localparam int DW = 16;
  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  // control and status fields
  localparam int CTRL_GO    = 0;
  localparam int CTRL_OP    = 1;
  localparam int STS_BUSY   = 0;
  localparam int STS_DONE   = 1;
  localparam int STS_FAIL   = 2;
  localparam int STS_SUSP   = 3;
  localparam int STS_ESTART = 4;
  localparam int STS_REFUSE = 5;
  localparam int STS_SECTGL = 6;
  localparam int STS_WORD   = 8;
  // reset values
  localparam logic [AW-1:0] ADDR_RST  = 20'h00000;
  localparam logic [DW-1:0] WDATA_RST = 16'h0000;
  // positions inside the operation status word
  localparam int DATA_POLL_BIT        = 7;
  localparam int PRIMARY_TOGGLE_BIT   = 6;
  localparam int TIMEOUT_FLAG_BIT     = 5;
  localparam int ERASE_TIMER_BIT      = 3;
  localparam int SECONDARY_TOGGLE_BIT = 2;
  // command addresses and codes
  localparam logic [AW-1:0] UNLOCK_A1        = 20'h00555;
  localparam logic [AW-1:0] UNLOCK_A2        = 20'h002aa;
  localparam logic [DW-1:0] CMD_UNLOCK1      = 16'h00aa;
  localparam logic [DW-1:0] CMD_UNLOCK2      = 16'h0055;
  localparam logic [DW-1:0] CMD_PROGRAM      = 16'h00a0;
  localparam logic [DW-1:0] CMD_ERASE_SETUP  = 16'h0080;
  localparam logic [DW-1:0] CMD_SECTOR_ERASE = 16'h0030;
  localparam logic [DW-1:0] CMD_CHIP_ERASE   = 16'h0010;
  localparam logic [DW-1:0] CMD_RESET        = 16'h00f0;
  localparam logic [DW-1:0] CMD_SUSPEND      = 16'h00b0;
  localparam logic [DW-1:0] CMD_RESUME       = 16'h0030;
  // bus cycle timing, least times rounded up
  localparam int CLK_MHZ    = 250;
  localparam int T_SETUP_NS = 10;
  localparam int T_ACC_NS   = 70;
  localparam int T_WP_NS    = 50;
  localparam int T_HOLD_NS  = 20;
  localparam int SETUP_CYC  = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_CYC    = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int WP_CYC     = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC   = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
  // operations software may start
  typedef enum logic [2:0] {
    OP_READ    = 3'b000,
    OP_PROGRAM = 3'b001,
    OP_SECTOR  = 3'b010,
    OP_CHIP    = 3'b011,
    OP_RESET   = 3'b100,
    OP_SUSPEND = 3'b101,
    OP_RESUME  = 3'b110
  } fls_op_t;
endpackage : fls_pkg

//--- fls_cyc_if.sv
// one flash bus cycle request and its answer
`timescale 1ns/1ps
interface fls_cyc_if;
  import fls_pkg::*;
  logic          req;
  logic          wr;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic          done;
  logic [DW-1:0] rdata;
  modport master (output req, wr, addr, wdata, input done, rdata);
  modport engine (input req, wr, addr, wdata, output done, rdata);
endinterface : fls_cyc_if

//--- fls_cyc_engine.sv
// runs single read or write cycles on the flash pins
`timescale 1ns/1ps
module fls_cyc_engine
  import fls_pkg::*;
#(
  parameter int SETUP_N = fls_pkg::SETUP_CYC,
  parameter int ACC_N   = fls_pkg::ACC_CYC,
  parameter int WP_N    = fls_pkg::WP_CYC,
  parameter int HOLD_N  = fls_pkg::HOLD_CYC
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  fls_cyc_if.engine                   cyc,
  input  wire logic [fls_pkg::DW-1:0] dq_i,
  output logic      [fls_pkg::DW-1:0] dq_o,
  output logic                        dq_oe_o,
  output logic      [fls_pkg::AW-1:0] a_o,
  output logic                        ce_n_o,
  output logic                        oe_n_o,
  output logic                        we_n_o
);
  typedef enum logic [1:0] {
    E_IDLE   = 2'b00,
    E_SETUP  = 2'b01,
    E_STROBE = 2'b10,
    E_HOLD   = 2'b11
  } fls_eng_t;

  fls_eng_t   state;
  logic [7:0] cnt;
  logic       wr;

  // ----------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------
  // ce and the strobe pulse on every cycle, so each status read is
  // a separate read cycle to the device
  always_ff @(posedge clk_i) begin
    cyc.done <= 1'b0;
    if (rst_i) begin
      state     <= E_IDLE;
      cnt       <= 8'h00;
      wr        <= 1'b0;
      a_o       <= '0;
      dq_o      <= '0;
      dq_oe_o   <= 1'b0;
      ce_n_o    <= 1'b1;
      oe_n_o    <= 1'b1;
      we_n_o    <= 1'b1;
      cyc.rdata <= '0;
    end else begin
      case (state)
        E_IDLE: begin
          // done guard: master lowers req only after this edge
          if (cyc.req && !cyc.done) begin
            a_o     <= cyc.addr;
            dq_o    <= cyc.wdata;
            wr      <= cyc.wr;
            dq_oe_o <= cyc.wr;
            ce_n_o  <= 1'b0;
            cnt     <= 8'(SETUP_N - 1);
            state   <= E_SETUP;
          end
        end
        E_SETUP: begin
          if (cnt == 8'h00) begin
            oe_n_o <= wr;
            we_n_o <= !wr;
            cnt    <= wr ? 8'(WP_N - 1) : 8'(ACC_N - 1);
            state  <= E_STROBE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        E_STROBE: begin
          if (cnt == 8'h00) begin
            oe_n_o <= 1'b1;
            we_n_o <= 1'b1;
            if (!wr) begin
              cyc.rdata <= dq_i;  // sampled after full access time
            end
            cnt   <= 8'(HOLD_N - 1);
            state <= E_HOLD;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        E_HOLD: begin
          if (cnt == 8'h00) begin
            ce_n_o   <= 1'b1;
            dq_oe_o  <= 1'b0;
            cyc.done <= 1'b1;
            state    <= E_IDLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        default: state <= E_IDLE;
      endcase
    end
  end
endmodule : fls_cyc_engine

//--- fls_poll_eval.sv
// compares two status words of one toggle check
`timescale 1ns/1ps
module fls_poll_eval
  import fls_pkg::*;
(
  input  wire logic [7:0] first_i,
  input  wire logic [7:0] second_i,
  output logic            toggling_o,
  output logic            sec_toggling_o,
  output logic            timeout_o
);
  // ----------------------------------------------------------------
  // toggle and timeout decode
  // ----------------------------------------------------------------
  // a steady primary toggle means the operation ended
  assign toggling_o = first_i[PRIMARY_TOGGLE_BIT]
                      ^ second_i[PRIMARY_TOGGLE_BIT];
  // secondary toggle only marks erase sectors, report only
  assign sec_toggling_o = first_i[SECONDARY_TOGGLE_BIT]
                          ^ second_i[SECONDARY_TOGGLE_BIT];
  // timeout flag is taken from the later read
  assign timeout_o = second_i[TIMEOUT_FLAG_BIT];
endmodule : fls_poll_eval

//--- fls_flash_poller.sv
// wishbone controlled flash command and status poller
`timescale 1ns/1ps
module fls_flash_poller
  import fls_pkg::*;
(
  input  wire logic                   CLK_SYS_I,
  input  wire logic                   SYS_RST_I,
  input  wire logic [7:0]             WB_ADR_I,
  input  wire logic [31:0]            WB_DAT_I,
  output logic      [31:0]            WB_DAT_O,
  input  wire logic                   WB_WE_I,
  input  wire logic [3:0]             WB_SEL_I,
  input  wire logic                   WB_CYC_I,
  input  wire logic                   WB_STB_I,
  output logic                        WB_ACK_O,
  output logic      [fls_pkg::AW-1:0] FLASH_A_O,
  input  wire logic [fls_pkg::DW-1:0] FLASH_DQ_I,
  output logic      [fls_pkg::DW-1:0] FLASH_DQ_O,
  output logic                        FLASH_DQ_OE_O,
  output logic                        FLASH_CE_N_O,
  output logic                        FLASH_OE_N_O,
  output logic                        FLASH_WE_N_O,
  output logic                        FLASH_RESET_N_O
);
  typedef enum logic [3:0] {
    S_IDLE       = 4'b0000,
    S_CMD        = 4'b0001,
    S_POLL_A     = 4'b0010,
    S_POLL_B     = 4'b0011,
    S_EVAL       = 4'b0100,
    S_RECHK_A    = 4'b0101,
    S_RECHK_B    = 4'b0110,
    S_RECHK_EVAL = 4'b0111,
    S_FINAL      = 4'b1000,
    S_RESET_CMD  = 4'b1001
  } fls_state_t;

  fls_cyc_if cyc ();

  fls_state_t    state;
  fls_op_t       cur_op;
  logic [2:0]    step;
  logic [AW-1:0] op_addr;
  logic [DW-1:0] op_wdata;
  logic [AW-1:0] erase_addr;
  logic [DW-1:0] rdata;
  logic [7:0]    stat_a;
  logic [7:0]    stat_b;
  logic          done;
  logic          fail;
  logic          suspended;
  logic          erase_started;
  logic          refused;
  logic          susp_req;
  logic          ack_q;
  logic          toggling;
  logic          sec_toggling;
  logic          timeout;
  logic          busy;
  logic          wb_req;
  logic          wb_wr;
  logic          go;
  fls_op_t       go_op;
  logic [31:0]   m_addr;
  logic [31:0]   m_wdata;
  logic [AW-1:0] tgt_addr;
  logic [AW+DW:0] seq;

  // ----------------------------------------------------------------
  // command sequence table
  // ----------------------------------------------------------------
  // returns {last, address, data} for one step of an operation
  function automatic logic [AW+DW:0] seq_word(
    input fls_op_t       op,
    input logic [2:0]    st,
    input logic [AW-1:0] a,
    input logic [DW-1:0] d
  );
    logic          last;
    logic [AW-1:0] wa;
    logic [DW-1:0] wd;
    last = 1'b0;
    wa   = UNLOCK_A1;
    wd   = CMD_UNLOCK1;
    case (st)
      3'd0: last = 1'b0;
      3'd1: begin
        wa = UNLOCK_A2;
        wd = CMD_UNLOCK2;
      end
      3'd2: wd = (op == OP_PROGRAM) ? CMD_PROGRAM : CMD_ERASE_SETUP;
      3'd3: begin
        if (op == OP_PROGRAM) begin
          wa   = a;
          wd   = d;
          last = 1'b1;
        end
      end
      3'd4: begin
        wa = UNLOCK_A2;
        wd = CMD_UNLOCK2;
      end
      default: begin
        last = 1'b1;
        wa   = (op == OP_SECTOR) ? a : UNLOCK_A1;
        wd   = (op == OP_SECTOR) ? CMD_SECTOR_ERASE : CMD_CHIP_ERASE;
      end
    endcase
    // single write commands
    if (op == OP_RESET || op == OP_SUSPEND || op == OP_RESUME) begin
      last = 1'b1;
      wa   = a;
      wd   = (op == OP_RESET)   ? CMD_RESET :
             (op == OP_SUSPEND) ? CMD_SUSPEND : CMD_RESUME;
    end
    seq_word = {last, wa, wd};
  endfunction : seq_word

  // byte lane merge for wishbone writes
  function automatic logic [31:0] merge(
    input logic [31:0] o,
    input logic [31:0] n,
    input logic [3:0]  s
  );
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction : merge

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  fls_cyc_engine u_engine (
    .clk_i   (CLK_SYS_I),
    .rst_i   (SYS_RST_I),
    .cyc     (cyc.engine),
    .dq_i    (FLASH_DQ_I),
    .dq_o    (FLASH_DQ_O),
    .dq_oe_o (FLASH_DQ_OE_O),
    .a_o     (FLASH_A_O),
    .ce_n_o  (FLASH_CE_N_O),
    .oe_n_o  (FLASH_OE_N_O),
    .we_n_o  (FLASH_WE_N_O)
  );

  fls_poll_eval u_eval (
    .first_i        (stat_a),
    .second_i       (stat_b),
    .toggling_o     (toggling),
    .sec_toggling_o (sec_toggling),
    .timeout_o      (timeout)
  );

  // ----------------------------------------------------------------
  // wishbone slave decode
  // ----------------------------------------------------------------
  // reset pin held inactive, device reset is done by command
  assign FLASH_RESET_N_O = 1'b1;
  assign busy    = (state != S_IDLE);
  assign wb_req  = WB_CYC_I && WB_STB_I;
  // writes land on the edge where the master sees ack
  assign wb_wr   = wb_req && WB_WE_I && ack_q;
  assign go      = wb_wr && (WB_ADR_I == REG_CTRL) && WB_SEL_I[0]
                   && WB_DAT_I[CTRL_GO];
  assign go_op   = fls_op_t'(WB_DAT_I[CTRL_OP +: 3]);
  assign m_addr  = merge({12'h000, op_addr}, WB_DAT_I, WB_SEL_I);
  assign m_wdata = merge({16'h0000, op_wdata}, WB_DAT_I, WB_SEL_I);
  assign WB_ACK_O = ack_q;

  // one wait state, ack drops the cycle after it was given
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      ack_q    <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      ack_q <= wb_req && !ack_q;
      case (WB_ADR_I)
        REG_CTRL:   WB_DAT_O <= {28'h0000000, cur_op, 1'b0};
        REG_ADDR:   WB_DAT_O <= {12'h000, op_addr};
        REG_WDATA:  WB_DAT_O <= {16'h0000, op_wdata};
        REG_STATUS: WB_DAT_O <= {16'h0000, stat_b, 1'b0, sec_toggling,
                                 refused, erase_started, suspended,
                                 fail, done, busy};
        REG_RDATA:  WB_DAT_O <= {16'h0000, rdata};
        default:    WB_DAT_O <= 32'h0000_0000;
      endcase
    end
  end

  // address and data registers, locked while an operation runs
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      op_addr  <= ADDR_RST;
      op_wdata <= WDATA_RST;
    end else if (wb_wr && !busy) begin
      if (WB_ADR_I == REG_ADDR) begin
        op_addr <= m_addr[AW-1:0];
      end
      if (WB_ADR_I == REG_WDATA) begin
        op_wdata <= m_wdata[DW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // flash cycle requests
  // ----------------------------------------------------------------
  // suspend and resume aim at the erase sector
  assign tgt_addr = (cur_op == OP_SUSPEND || cur_op == OP_RESUME)
                    ? erase_addr : op_addr;
  assign seq = seq_word(cur_op, step, tgt_addr, op_wdata);

  always_comb begin
    cyc.req   = 1'b0;
    cyc.wr    = 1'b0;
    cyc.addr  = tgt_addr;  // polls stay in the target sector
    cyc.wdata = seq[DW-1:0];
    case (state)
      S_CMD: begin
        cyc.req  = !cyc.done;
        cyc.wr   = 1'b1;
        cyc.addr = seq[AW+DW-1:DW];
      end
      S_RESET_CMD: begin
        cyc.req   = !cyc.done;
        cyc.wr    = 1'b1;
        cyc.wdata = CMD_RESET;
      end
      S_POLL_A, S_POLL_B, S_RECHK_A, S_RECHK_B, S_FINAL:
        cyc.req = !cyc.done;
      default: cyc.req = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // operation sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      state         <= S_IDLE;
      cur_op        <= OP_READ;
      step          <= 3'd0;
      erase_addr    <= ADDR_RST;
      rdata         <= WDATA_RST;
      stat_a        <= 8'h00;
      stat_b        <= 8'h00;
      done          <= 1'b0;
      fail          <= 1'b0;
      suspended     <= 1'b0;
      erase_started <= 1'b0;
      refused       <= 1'b0;
      susp_req      <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          if (go) begin
            // no second erase, resume only from suspend
            if (((go_op == OP_SECTOR || go_op == OP_CHIP) && suspended)
                || (go_op == OP_RESUME && !suspended)
                || go_op == OP_SUSPEND) begin
              refused <= 1'b1;
            end else begin
              cur_op  <= go_op;
              step    <= 3'd0;
              done    <= 1'b0;
              fail    <= 1'b0;
              refused <= 1'b0;
              if (go_op == OP_SECTOR || go_op == OP_CHIP) begin
                erase_addr    <= op_addr;
                erase_started <= 1'b0;
              end
              if (go_op == OP_RESET) begin
                suspended <= 1'b0;
              end
              state <= (go_op == OP_READ) ? S_FINAL : S_CMD;
            end
          end
        end
        S_CMD: begin
          if (cyc.done) begin
            step <= step + 3'd1;
            if (seq[AW+DW]) begin
              if (cur_op == OP_RESET) begin
                done  <= 1'b1;
                state <= S_IDLE;
              end else begin
                state <= S_POLL_A;
              end
            end
          end
        end
        S_POLL_A: begin
          if (cyc.done) begin
            stat_a <= cyc.rdata[7:0];  // first read stored
            if (cur_op == OP_SECTOR
                && cyc.rdata[ERASE_TIMER_BIT]) begin
              erase_started <= 1'b1;  // erase under way
            end
            state <= S_POLL_B;
          end
        end
        S_POLL_B: begin
          if (cyc.done) begin
            stat_b <= cyc.rdata[7:0];  // second read back to back
            state  <= S_EVAL;
          end
        end
        S_EVAL: begin
          if (!toggling) begin
            state <= S_FINAL;  // finished, fetch array data
          end else if (timeout) begin
            state <= S_RECHK_A;  // timeout seen, retest toggle
          end else if (susp_req) begin
            // only suspend may go in during sector erase
            susp_req <= 1'b0;
            cur_op   <= OP_SUSPEND;
            step     <= 3'd0;
            state    <= S_CMD;
          end else begin
            // every new check starts with a fresh pair
            state <= S_POLL_A;
          end
        end
        S_RECHK_A: begin
          if (cyc.done) begin
            stat_a <= cyc.rdata[7:0];
            state  <= S_RECHK_B;
          end
        end
        S_RECHK_B: begin
          if (cyc.done) begin
            stat_b <= cyc.rdata[7:0];
            state  <= S_RECHK_EVAL;
          end
        end
        S_RECHK_EVAL: begin
          // stopped: late success; still toggling: failure
          state <= toggling ? S_RESET_CMD : S_FINAL;
        end
        S_FINAL: begin
          if (cyc.done) begin
            rdata <= cyc.rdata;
            done  <= 1'b1;
            if (cur_op == OP_SUSPEND) begin
              suspended <= 1'b1;  // steady toggle in suspend
            end
            if (cur_op == OP_RESUME || cur_op == OP_SECTOR) begin
              suspended <= 1'b0;
            end
            state <= S_IDLE;
          end
        end
        S_RESET_CMD: begin
          if (cyc.done) begin
            fail      <= 1'b1;  // back to array reads
            done      <= 1'b1;
            suspended <= 1'b0;
            state     <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
      // suspend request latched during sector erase, set wins
      if (go && busy) begin
        if (go_op == OP_SUSPEND && cur_op == OP_SECTOR
            && (state == S_POLL_A || state == S_POLL_B
                || state == S_EVAL)) begin
          susp_req <= 1'b1;
        end else begin
          refused <= 1'b1;
        end
      end
      if (state == S_IDLE) begin
        susp_req <= 1'b0;
      end
    end
  end
endmodule : fls_flash_poller

//--- fls_poller_sva.sv
// checker for the poller's bus and flash pins
`timescale 1ns/1ps
module fls_poller_sva
  import fls_pkg::*;
(
  input wire logic        CLK_SYS_I,
  input wire logic        SYS_RST_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic        WB_WE_I,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_ACK_O,
  input wire logic [31:0] WB_DAT_O,
  input wire logic [19:0] FLASH_A_O,
  input wire logic        FLASH_DQ_OE_O,
  input wire logic        FLASH_CE_N_O,
  input wire logic        FLASH_OE_N_O,
  input wire logic        FLASH_WE_N_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);
  logic [7:0] olow;
  // length of the current output-gate pulse
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) olow <= 8'h00;
    else olow <= FLASH_OE_N_O ? 8'h00 : olow + 8'h01;
  end
  a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
    |=> WB_ACK_O) else $error("ack late");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(WB_STB_I))
    else $error("ack without request");
  a_unmapped_zero: assert property (WB_STB_I && !WB_WE_I && !WB_ACK_O
    && WB_ADR_I > 8'h10 |=> WB_DAT_O == 32'h0) else $error("unmapped");
  a_read_gate: assert property (
    !FLASH_OE_N_O |-> !FLASH_CE_N_O && FLASH_WE_N_O && !FLASH_DQ_OE_O)
    else $error("read gate");
  a_write_drive: assert property (
    !FLASH_WE_N_O |-> !FLASH_CE_N_O && FLASH_DQ_OE_O)
    else $error("write drive");
  a_oe_width: assert property (
    $rose(FLASH_OE_N_O) |-> olow == ACC_CYC) else $error("oe width");
  a_addr_hold: assert property (
    !FLASH_CE_N_O && !$past(FLASH_CE_N_O) |-> $stable(FLASH_A_O))
    else $error("address moved");
  a_ce_gap: assert property (
    $rose(FLASH_CE_N_O) |=> FLASH_CE_N_O) else $error("ce gap");
  c_write: cover property (!FLASH_WE_N_O);
  c_read: cover property ($rose(FLASH_OE_N_O));
  c_bus_read: cover property (WB_ACK_O && !WB_WE_I);
endmodule : fls_poller_sva
bind fls_flash_poller fls_poller_sva fls_poller_sva_inst (.*);

//--- fls_flash_model.sv
// behavioural flash device answering status polls
`timescale 1ns/1ps
module fls_flash_model
  import fls_pkg::*;
#(
  parameter int            BUSY_N = 12,
  parameter logic [AW-1:0] PROT_A = 20'h0f000 // locked word
) (
  input  wire logic [AW-1:0] a_i,
  input  wire logic [DW-1:0] dq_i,
  input  wire logic          ce_n_i,
  input  wire logic          oe_n_i,
  input  wire logic          we_n_i,
  output logic      [DW-1:0] dq_o
);
  logic [DW-1:0] arr = 16'hffff;
  logic [DW-1:0] prev = 16'h0000;
  logic [DW-1:0] last = 16'h0000;
  logic [1:0] mode = 2'h0; // 0 read, 1 program, 2 erase, 3 suspended
  logic tgl = 1'b0;
  logic tg2 = 1'b0;
  logic tmo = 1'b0;
  logic hit = 1'b0; // program asked a 0 to become 1
  logic [AW-1:0] ea = 20'h00000; // address of the last erase command
  logic off = 1'b0; // an erase poll left the erase sector
  int left = 0;
  logic [7:0] sts;
  // status word per mode
  always_comb begin
    case (mode)
      2'h1: sts = {~last[7], tgl, tmo, 5'h00};
      2'h2: sts = {1'b0, tgl, tmo, 2'h1, tg2, 2'h0};
      2'h3: sts = {1'b1, tgl, 3'h0, tg2, 2'h0};
      default: sts = arr[7:0];
    endcase
  end
  // released bus shows the inverse, never a stale copy
  assign dq_o = (!ce_n_i && !oe_n_i) ? {arr[15:8], sts} : ~arr;
  // command decode on the write strobe's rising edge
  always @(posedge we_n_i) begin
    if (!ce_n_i) begin
      if (prev == CMD_PROGRAM && mode == 2'h0) begin
        hit = |(dq_i & ~arr) && a_i != PROT_A;
        if (a_i != PROT_A) arr = arr & dq_i;
        last = dq_i;
        mode = 2'h1;
        left = (a_i == PROT_A) ? 2 : BUSY_N; // locked: brief toggle
      end else if (dq_i == CMD_RESET && mode != 2'h2) begin
        mode = 2'h0;
        tmo = 1'b0;
        hit = 1'b0;
      end else if (dq_i == CMD_SUSPEND && mode == 2'h2) mode = 2'h3;
      else if (dq_i == CMD_RESUME && mode == 2'h3) mode = 2'h2;
      else if (mode == 2'h0 && prev == CMD_UNLOCK2 && (dq_i ==
          CMD_SECTOR_ERASE || dq_i == CMD_CHIP_ERASE)) begin
        mode = 2'h2;
        left = 4 * BUSY_N;
        ea = a_i;
      end
      prev = dq_i;
    end
  end
  // each output-gated read advances the primary toggle in program and erase mode, the secondary in erase and suspend mode
  always @(posedge oe_n_i) begin
    if (!ce_n_i && mode != 2'h0) begin
      if (mode[1] && a_i != ea) off = 1'b1;
      if (mode != 2'h3) tgl = ~tgl;
      if (mode != 2'h1) tg2 = ~tg2;
      if (mode != 2'h3 && left > 0) left--;
      if (mode != 2'h3 && left == 0) begin
        if (hit) tmo = 1'b1;
        else begin
          if (mode == 2'h2) arr = 16'hffff;
          mode = 2'h0;
        end
      end
    end
  end
endmodule : fls_flash_model

//--- testbench.sv
// self-checking bench for the flash status poller
`timescale 1ns/1ps
module testbench;
  import fls_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [31:0] rdat, v;
  logic ack, foe, fce, fog, fwe, frst;
  logic [AW-1:0] fa;
  logic [DW-1:0] fdi, fdo;
  int fails = 0;
  int n_compared = 0;
  fls_flash_poller fls_flash_poller_inst (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .WB_ADR_I(adr), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_WE_I(we), .WB_SEL_I(4'hf), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_ACK_O(ack), .FLASH_A_O(fa), .FLASH_DQ_I(fdi),
    .FLASH_DQ_O(fdo), .FLASH_DQ_OE_O(foe), .FLASH_CE_N_O(fce),
    .FLASH_OE_N_O(fog), .FLASH_WE_N_O(fwe), .FLASH_RESET_N_O(frst));
  fls_flash_model fls_flash_model_inst (.a_i(fa), .dq_i(fdo),
    .ce_n_i(fce), .oe_n_i(fog), .we_n_i(fwe), .dq_o(fdi));
  initial forever #2 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    v = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic go(input fls_op_t op, input logic [31:0] a, d);
    bus(1'b1, REG_ADDR, a);
    bus(1'b1, REG_WDATA, d);
    bus(1'b1, REG_CTRL, {28'h0, op, 1'b1});
  endtask : go
  task automatic settle();
    do bus(1'b0, REG_STATUS, 32'h0); while (v[STS_BUSY] !== 1'b0);
  endtask : settle
  task automatic t_regs();
    bus(1'b0, REG_STATUS, 32'h0);
    chk("status reset", v, 32'h0);
    chk("reset pin", frst, 1'b1);
    bus(1'b1, 8'h20, 32'h5a);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", v, 32'h0);
    bus(1'b1, REG_CTRL, {28'h0, OP_SUSPEND, 1'b1});
    bus(1'b0, REG_STATUS, 32'h0);
    chk("idle suspend", v[STS_REFUSE], 1'b1);
  endtask : t_regs
  task automatic t_prog();
    go(OP_PROGRAM, 32'h00100, 32'h00f0);
    settle();
    chk("prog fail", v[STS_FAIL], 1'b0);
    chk("prog done", v[STS_DONE], 1'b1);
    bus(1'b0, REG_RDATA, 32'h0);
    chk("prog data", v, 32'h00f0);
  endtask : t_prog
  task automatic t_bad();
    go(OP_PROGRAM, 32'h00100, 32'h00ff);
    settle();
    chk("bad fail", v[STS_FAIL], 1'b1);
    chk("bad flag", v[STS_WORD+TIMEOUT_FLAG_BIT], 1'b1);
    chk("bad reset", fls_flash_model_inst.mode, 2'h0);
  endtask : t_bad
  task automatic t_erase();
    go(OP_SECTOR, 32'h00800, 32'h0);
    do bus(1'b0, REG_STATUS, 32'h0); while (v[STS_ESTART] !== 1'b1);
    bus(1'b1, REG_CTRL, {28'h0, OP_SUSPEND, 1'b1});
    settle();
    chk("suspended", v[STS_SUSP], 1'b1);
    chk("susp poll", v[STS_WORD+DATA_POLL_BIT], 1'b1);
    chk("erase tgl2", v[STS_SECTGL], 1'b1);
    bus(1'b1, REG_ADDR, 32'h0); // later polls must keep the erase sector
    bus(1'b1, REG_CTRL, {28'h0, OP_CHIP, 1'b1});
    bus(1'b0, REG_STATUS, 32'h0);
    chk("second erase", v[STS_REFUSE], 1'b1);
    bus(1'b1, REG_CTRL, {28'h0, OP_RESUME, 1'b1});
    settle();
    chk("erase start", v[STS_ESTART], 1'b1);
    chk("erase fail", v[STS_FAIL], 1'b0);
    bus(1'b0, REG_RDATA, 32'h0);
    chk("erased", v, 32'h0000ffff);
    chk("poll addr", fls_flash_model_inst.off, 1'b0);
  endtask : t_erase
  task automatic t_chip();
    go(OP_CHIP, 32'h00555, 32'h0);
    settle();
    chk("chip start", v[STS_ESTART], 1'b0);
    chk("chip done", v[STS_DONE], 1'b1);
    go(OP_READ, 32'h00100, 32'h0);
    settle();
    bus(1'b0, REG_RDATA, 32'h0);
    chk("read", v, 32'h0000ffff);
    // locked word: short toggle, no failure, data kept
    go(OP_PROGRAM, 32'h0f000, 32'h0);
    settle();
    chk("prot fail", v[STS_FAIL], 1'b0);
    bus(1'b0, REG_RDATA, 32'h0);
    chk("prot data", v, 32'h0000ffff);
    go(OP_RESET, 32'h0, 32'h0);
    settle();
    chk("reset done", v[STS_DONE], 1'b1);
  endtask : t_chip
  task automatic conclude();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // hang guard, far beyond the expected run
  initial begin
    #200000;
    fails++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_prog();
    t_bad();
    t_erase();
    t_chip();
    conclude();
  end
endmodule : testbench
